// >>> fan_pulse_overflow_bit_pkg.sv
// Constants shared by the fan tachometer and alarm monitor.
// Assumes a 100 MHz system clock.
`default_nettype none
package fan_pulse_overflow_bit_pkg;
  // ----------------------------------------
  // Register indices (command byte values)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h02;
  localparam logic [7:0] ADDR_PIN_DEF = 8'h04;
  localparam logic [7:0] ADDR_DAC = 8'h06;
  localparam logic [7:0] ADDR_ALARM_MASK = 8'h08;
  localparam logic [7:0] ADDR_ALARM_FLAGS = 8'h0A;
  localparam logic [7:0] ADDR_COUNT0 = 8'h0C;
  localparam logic [7:0] ADDR_WINDOW_SEL = 8'h16;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CONFIG = 8'h0A;
  localparam logic [7:0] RST_PIN_DEF = 8'hFF;
  localparam logic [7:0] RST_DAC = 8'h00;
  localparam logic [4:0] RST_ALARM_MASK = 5'h00;
  localparam logic [4:0] RST_ALARM_FLAGS = 5'h00;
  localparam logic [1:0] RST_WINDOW_CODE = 2'h2;
  localparam logic [7:0] RST_COUNT = 8'h00;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MODE_LSB = 4;
  localparam int ALM_PIN_TWO = 4;
  localparam int ALM_PIN_ONE = 3;
  localparam int ALM_OVERFLOW = 2;
  localparam int ALM_MIN = 1;
  localparam int ALM_MAX = 0;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] LEVEL_FULL = 8'hFF;
  localparam logic [7:0] LEVEL_OFF = 8'h00;
  localparam logic [1:0] PIN0_AS_ALERT = 2'h1;
  localparam logic [1:0] PIN_DRIVE_LOW = 2'h2;
  localparam logic [1:0] PIN1_AS_FULL_ON = 2'h1;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_KHZ = 100000;
  localparam int WINDOW_BASE_MS = 250;
  localparam int WINDOW_BASE_CYCLES = WINDOW_BASE_MS * CLK_KHZ;
  typedef enum logic [1:0] {
    MODE_FULL_ON, MODE_SHUTDOWN, MODE_CLOSED, MODE_OPEN
  } fan_mode_t;
endpackage
`default_nettype wire

// >>> window_if.sv
// Window-end strobe shared between the monitor and its pulse counters.
// Assumes one clock domain.
`timescale 1ns/1ns
`default_nettype none
interface window_if;
  logic windowEnd;
  modport src (output windowEnd);
  modport dst (input windowEnd);
endinterface
`default_nettype wire

// >>> tick_divider.sv
// Divider giving a one-cycle enable every PERIOD clocks.
// Assumes PERIOD is at least 2.
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
  parameter int PERIOD = 25000000
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  output logic tick
);
  logic [31:0] cnt_ff;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_ff == 32'(PERIOD - 1)) begin
      cnt_ff <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> pulse_counter.sv
// Counts rising edges of one tachometer input per window.
// Assumes the input is synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module pulse_counter (
  input wire logic clk_sys,
  input wire logic rst_b,
  window_if.dst win,
  input wire logic pulseIn,
  output logic [7:0] countOut,
  output logic overflow
);
  import fan_pulse_overflow_bit_pkg::*;
  logic prev_ff;
  logic [7:0] acc_ff;
  logic ovf_ff;
  logic edgeSeen;
  assign edgeSeen = pulseIn && !prev_ff;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) prev_ff <= 1'b0;
    else prev_ff <= pulseIn;
  end

  // Accumulator saturates; a further edge marks overflow
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acc_ff <= RST_COUNT;
      ovf_ff <= 1'b0;
    end else if (win.windowEnd) begin
      acc_ff <= {7'h0, edgeSeen};
      ovf_ff <= 1'b0;
    end else if (edgeSeen) begin
      if (acc_ff == COUNT_MAX) ovf_ff <= 1'b1;
      else acc_ff <= acc_ff + 8'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      countOut <= RST_COUNT;
      overflow <= 1'b0;
    end else if (win.windowEnd) begin
      countOut <= acc_ff;
      overflow <= ovf_ff || (edgeSeen && acc_ff == COUNT_MAX);
    end
  end

  a_count_saturate: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    win.windowEnd && ovf_ff |=> countOut == COUNT_MAX && overflow)
    else $error("overflowed window did not report 255");
  a_window_restart: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    win.windowEnd && !edgeSeen |=> acc_ff == 8'h0)
    else $error("count did not restart after window");
endmodule
`default_nettype wire

// >>> fan_pulse_overflow_bit_alarm_monitor.sv
// Fan tachometer count, window timing, alarm flags and drive selection.
// Assumes a host-side protocol engine presents byte register accesses,
// tachometer and pin inputs are synchronous to clk_sys.
//
// Behaviour
// - Each count register holds pulses seen on its input per window.
// - Over 255 pulses per window reports 255 and raises overflow alarm.
// - Window code selects 0.25 s times two to the code.
// - Upper six bits of window select register read zero.
// - Reset clears counts and selects one-second window.
// - Mask bits: pin two, pin one, overflow, minimum, maximum; reset zero.
// - Pin alarm flags set while the enabled pin is low.
// - Flags: overflow bit 2, minimum bit 1, maximum bit 0.
// - Reading flags clears only bits whose cause has gone.
// - Flags set only when enabled; min/max only in closed loop.
// - Pin zero as alert drives low on any enabled fault.
// - Mode from configuration bits 5:4.
// - Open loop drive follows the DAC setting register unless pin one, defined as full-on, is low.
// - Closed loop ignores the DAC setting register.
// - Reset disables alarms, prescaler four, full-on mode.
`timescale 1ns/1ns
`default_nettype none
module fan_pulse_overflow_bit_alarm_monitor #(
  parameter int NUM_PULSE = 4,
  parameter int BASE_CYCLES = fan_pulse_overflow_bit_pkg::WINDOW_BASE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic [NUM_PULSE-1:0] pulseInput,
  input wire logic generalPinOneIn,
  input wire logic generalPinTwoIn,
  input wire logic levelAtMin,
  input wire logic levelAtMax,
  input wire logic [7:0] regulatorLevel,
  output logic generalPinZeroOut,
  output logic generalPinZeroOe,
  output logic [7:0] driveLevelCode,
  output fan_pulse_overflow_bit_pkg::fan_mode_t fanMode,
  output logic [2:0] prescaleCode
);
  import fan_pulse_overflow_bit_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] config_ff;
  logic [7:0] pinDef_ff;
  logic [7:0] dac_ff;
  logic [4:0] alarmMask_ff;
  logic [4:0] alarmFlags_ff;
  logic [1:0] windowCode_ff;
  logic [7:0] countVal [NUM_PULSE];
  logic [NUM_PULSE-1:0] countOvf;
  fan_mode_t curMode;
  logic hwFullOn;
  logic [4:0] cond;
  logic flagRead;

  assign curMode = fan_mode_t'(config_ff[MODE_LSB+1:MODE_LSB]);
  assign hwFullOn = (pinDef_ff[3:2] == PIN1_AS_FULL_ON) && !generalPinOneIn;
  assign flagRead = regRdEn && regAddr == ADDR_ALARM_FLAGS;

  // Only defined bits are stored, so reserved bits cannot read back
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      config_ff <= RST_CONFIG;
      pinDef_ff <= RST_PIN_DEF;
      dac_ff <= RST_DAC;
      alarmMask_ff <= RST_ALARM_MASK;
      windowCode_ff <= RST_WINDOW_CODE;
    end else if (regWrEn) begin
      case (regAddr)
        ADDR_CONFIG: config_ff <= {2'h0, regWrData[5:0]};
        ADDR_PIN_DEF: pinDef_ff <= regWrData;
        ADDR_DAC: dac_ff <= regWrData;
        ADDR_ALARM_MASK: alarmMask_ff <= regWrData[4:0];
        ADDR_WINDOW_SEL: windowCode_ff <= regWrData[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Window timing
  // ----------------------------------------
  window_if winIf ();
  logic baseTick;
  logic [2:0] tickCnt_ff;
  logic [2:0] lastTick;

  tick_divider #(.PERIOD(BASE_CYCLES)) u_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .tick(baseTick)
  );

  assign lastTick = 3'((4'h1 << windowCode_ff) - 4'h1);

  // Compare with >= so a shortened code mid-window still closes it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tickCnt_ff <= 3'h0;
      winIf.windowEnd <= 1'b0;
    end else if (baseTick && tickCnt_ff >= lastTick) begin
      tickCnt_ff <= 3'h0;
      winIf.windowEnd <= 1'b1;
    end else begin
      if (baseTick) tickCnt_ff <= tickCnt_ff + 3'h1;
      winIf.windowEnd <= 1'b0;
    end
  end

  for (genvar i = 0; i < NUM_PULSE; i++) begin : g_cnt
    pulse_counter u_cnt (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .win(winIf.dst),
      .pulseIn(pulseInput[i]),
      .countOut(countVal[i]),
      .overflow(countOvf[i])
    );
  end

  // ----------------------------------------
  // Alarms
  // ----------------------------------------
  always_comb begin
    cond = 5'h0;
    cond[ALM_PIN_TWO] = !generalPinTwoIn;
    cond[ALM_PIN_ONE] = !generalPinOneIn;
    cond[ALM_OVERFLOW] = |countOvf;
    cond[ALM_MIN] = levelAtMin && curMode == MODE_CLOSED;
    cond[ALM_MAX] = levelAtMax && curMode == MODE_CLOSED;
  end

  // Set beats clear: a live, enabled cause always re-sets its flag
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) alarmFlags_ff <= RST_ALARM_FLAGS;
    else if (flagRead)
      alarmFlags_ff <= (alarmFlags_ff & cond) | (cond & alarmMask_ff);
    else
      alarmFlags_ff <= alarmFlags_ff | (cond & alarmMask_ff);
  end

  // Open drain: data is always low, enable carries the level
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      generalPinZeroOut <= 1'b0;
      generalPinZeroOe <= 1'b0;
    end else begin
      generalPinZeroOut <= 1'b0;
      case (pinDef_ff[1:0])
        PIN0_AS_ALERT: generalPinZeroOe <= |alarmFlags_ff;
        PIN_DRIVE_LOW: generalPinZeroOe <= 1'b1;
        default: generalPinZeroOe <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Drive selection
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      driveLevelCode <= LEVEL_FULL;
      fanMode <= MODE_FULL_ON;
      prescaleCode <= RST_CONFIG[2:0];
    end else begin
      fanMode <= curMode;
      prescaleCode <= config_ff[2:0];
      if (hwFullOn) driveLevelCode <= LEVEL_FULL;
      else begin
        case (curMode)
          MODE_OPEN: driveLevelCode <= dac_ff;
          MODE_CLOSED: driveLevelCode <= regulatorLevel;
          MODE_SHUTDOWN: driveLevelCode <= LEVEL_OFF;
          default: driveLevelCode <= LEVEL_FULL;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Read port, one cycle latency
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) regRdData <= 8'h00;
    else if (regRdEn) begin
      regRdData <= 8'h00;
      case (regAddr)
        ADDR_CONFIG: regRdData <= config_ff;
        ADDR_PIN_DEF: regRdData <= pinDef_ff;
        ADDR_DAC: regRdData <= dac_ff;
        ADDR_ALARM_MASK: regRdData <= {3'h0, alarmMask_ff};
        ADDR_ALARM_FLAGS: regRdData <= {3'h0, alarmFlags_ff};
        ADDR_WINDOW_SEL: regRdData <= {6'h0, windowCode_ff};
        default: begin
          for (int k = 0; k < NUM_PULSE; k++) begin
            if (regAddr == 8'(ADDR_COUNT0 + 2 * k))
              regRdData <= countVal[k];
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_window_length: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(winIf.windowEnd) |-> $past(tickCnt_ff) >= $past(lastTick))
    else $error("window closed before its tick count");
  a_window_upper_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    regRdEn && regAddr == ADDR_WINDOW_SEL |=> regRdData[7:2] == 6'h0)
    else $error("window select upper bits nonzero");
  a_flag_needs_mask: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (alarmFlags_ff & ~$past(alarmFlags_ff) & ~$past(alarmMask_ff)) == 5'h0)
    else $error("flag set without enable");
  a_flag_keep_cause: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    flagRead |=> (($past(cond & alarmMask_ff) & ~alarmFlags_ff) == 5'h0)
      && ((alarmFlags_ff & ~$past(cond)) == 5'h0))
    else $error("flag read cleared a live cause or kept a gone one");
  a_minmax_closed: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    curMode != MODE_CLOSED |-> cond[1:0] == 2'h0)
    else $error("level alarm outside closed loop");
  a_pin_alarm: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !generalPinOneIn && alarmMask_ff[ALM_PIN_ONE]
      |=> alarmFlags_ff[ALM_PIN_ONE])
    else $error("pin one low did not set its flag");
  a_alert_drive: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    pinDef_ff[1:0] == PIN0_AS_ALERT && |alarmFlags_ff
      |=> generalPinZeroOe && !generalPinZeroOut)
    else $error("alert not driven low");
  a_open_loop_dac: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    curMode == MODE_OPEN && !hwFullOn |=> driveLevelCode == $past(dac_ff))
    else $error("open loop drive differs from DAC");
  a_closed_ignores_dac: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    curMode == MODE_CLOSED && !hwFullOn
      |=> driveLevelCode == $past(regulatorLevel))
    else $error("closed loop drive not from regulator");

  // ----------------------------------------
  // Flag, drive, readback and count checks
  // ----------------------------------------
  a_pin_two_alarm: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !generalPinTwoIn && alarmMask_ff[ALM_PIN_TWO]
      |=> alarmFlags_ff[ALM_PIN_TWO])
    else $error("pin two low did not set its flag");
  a_overflow_alarm: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    |countOvf && alarmMask_ff[ALM_OVERFLOW]
      |=> alarmFlags_ff[ALM_OVERFLOW])
    else $error("count overflow did not set its flag");
  a_mask_upper_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    regRdEn && regAddr == ADDR_ALARM_MASK
      |=> regRdData[7:5] == 3'h0)
    else $error("alarm mask upper bits nonzero");
  a_flag_upper_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    regRdEn && regAddr == ADDR_ALARM_FLAGS
      |=> regRdData[7:5] == 3'h0)
    else $error("alarm flag upper bits nonzero");
  a_mode_output: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    1'b1 |=> fanMode == $past(curMode))
    else $error("mode output does not follow configuration");
  a_full_on_drive: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    curMode == MODE_FULL_ON
      |=> driveLevelCode == LEVEL_FULL)
    else $error("full-on mode drive not at full level");
  a_shutdown_drive: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    curMode == MODE_SHUTDOWN && !hwFullOn
      |=> driveLevelCode == LEVEL_OFF)
    else $error("shutdown mode drive not off");
  a_count_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !winIf.windowEnd
      |=> $stable(countVal[0]))
    else $error("count changed between window ends");
  a_alert_release: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    pinDef_ff[1:0] == PIN0_AS_ALERT && alarmFlags_ff == 5'h0
      |=> !generalPinZeroOe)
    else $error("alert held with no flag set");
endmodule
`default_nettype wire

// >>> fan_pulse_model.sv
// Fan tachometer model: bursts of pulses or a free-running train.
// Assumes the bench loads burst lengths with a one-cycle strobe.
`timescale 1ns/1ns
`default_nettype none
module fan_pulse_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic freeRun,
  input wire logic burstGo,
  input wire logic [35:0] burstLen,
  output logic [3:0] pulseOut
);
  logic [1:0] phase;
  logic [8:0] left [4];
  // One clock low between pulses keeps every edge countable
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase <= 2'h0;
      pulseOut <= 4'h0;
      for (int i = 0; i < 4; i++) left[i] <= 9'h000;
    end else begin
      phase <= phase + 2'h1;
      for (int i = 0; i < 4; i++) begin
        if (burstGo) begin
          left[i] <= burstLen[9*i +: 9];
          pulseOut[i] <= 1'b0;
        end else if (freeRun) begin
          pulseOut[i] <= (phase == 2'h0);
        end else if (left[i] != 9'h000 && !pulseOut[i]) begin
          pulseOut[i] <= 1'b1;
          left[i] <= left[i] - 9'h001;
        end else begin
          pulseOut[i] <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> fan_pulse_overflow_bit_alarm_monitor_bench.sv
// Self-checking bench for the fan tachometer and alarm monitor.
// Assumes a short window base so all window codes fit the run.
`timescale 1ns/1ns
`default_nettype none
module fan_pulse_overflow_bit_alarm_monitor_bench;
  import fan_pulse_overflow_bit_pkg::*;
  localparam int BASE = 200;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic regWrEn = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic regRdEn = 1'b0;
  logic [7:0] regRdData;
  logic [3:0] pulseInput;
  logic generalPinOneIn = 1'b1;
  logic generalPinTwoIn = 1'b1;
  logic levelAtMin = 1'b0;
  logic levelAtMax = 1'b0;
  logic [7:0] regulatorLevel = 8'h33;
  logic generalPinZeroOut;
  logic generalPinZeroOe;
  logic [7:0] driveLevelCode;
  fan_mode_t fanMode;
  logic [2:0] prescaleCode;
  logic freeRun = 1'b0;
  logic burstGo = 1'b0;
  logic [35:0] burstLen = 36'h0;
  logic [7:0] expCnt [4] = '{8'h64, 8'h0A, 8'hFF, 8'hFF};
  logic [7:0] expDrive [4] = '{8'hFF, 8'h00, 8'h33, 8'h40};
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 clk_sys = ~clk_sys;
  // Cycle count since release; window ends fall near multiples of it
  always @(posedge clk_sys) if (rst_b) cyc <= cyc + 1;
  fan_pulse_overflow_bit_alarm_monitor #(.NUM_PULSE(4), .BASE_CYCLES(BASE)) i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .pulseInput(pulseInput),
    .generalPinOneIn(generalPinOneIn), .generalPinTwoIn(generalPinTwoIn),
    .levelAtMin(levelAtMin), .levelAtMax(levelAtMax),
    .regulatorLevel(regulatorLevel), .generalPinZeroOut(generalPinZeroOut),
    .generalPinZeroOe(generalPinZeroOe), .driveLevelCode(driveLevelCode),
    .fanMode(fanMode), .prescaleCode(prescaleCode));
  fan_pulse_model i_fan (
    .clk_sys(clk_sys), .rst_b(rst_b), .freeRun(freeRun),
    .burstGo(burstGo), .burstLen(burstLen), .pulseOut(pulseInput));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    // Data stands until the next read, so look one edge later
    @(posedge clk_sys);
    chk(what, regRdData, exp);
  endtask
  task automatic waitTo(input int t);
    while (cyc < t) @(posedge clk_sys);
  endtask
  task automatic results;
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(ADDR_WINDOW_SEL, 8'h02, "window select");
    rd(ADDR_ALARM_MASK, 8'h00, "mask");
    rd(ADDR_ALARM_FLAGS, 8'h00, "flags");
    for (int i = 0; i < 4; i++)
      rd(ADDR_COUNT0 + 8'(2*i), 8'h00, "count");
    rd(ADDR_CONFIG, 8'h0A, "config");
    chk("mode", {6'h00, fanMode}, 8'h00);
    chk("prescale", {5'h00, prescaleCode}, 8'h02);
    chk("drive", driveLevelCode, 8'hFF);
    rd(8'h01, 8'h00, "unmapped");
    wr(ADDR_ALARM_FLAGS, 8'hFF);
    rd(ADDR_ALARM_FLAGS, 8'h00, "flags read only");
    wr(ADDR_WINDOW_SEL, 8'hFF);
    rd(ADDR_WINDOW_SEL, 8'h03, "window upper bits");
    wr(ADDR_WINDOW_SEL, 8'h02);
    wr(ADDR_ALARM_MASK, 8'hFF);
    rd(ADDR_ALARM_MASK, 8'h1F, "mask upper bits");
    wr(ADDR_ALARM_MASK, 8'h04);
    // Burst sits inside the second window, clear of both ends
    waitTo(850);
    @(posedge clk_sys);
    burstLen <= {9'h12C, 9'h0FF, 9'h00A, 9'h064};
    burstGo <= 1'b1;
    @(posedge clk_sys);
    burstGo <= 1'b0;
    waitTo(1650);
    for (int i = 0; i < 4; i++)
      rd(ADDR_COUNT0 + 8'(2*i), expCnt[i], "count");
    rd(ADDR_ALARM_FLAGS, 8'h04, "overflow flag");
    waitTo(2450);
    for (int i = 0; i < 4; i++)
      rd(ADDR_COUNT0 + 8'(2*i), 8'h00, "restart");
    rd(ADDR_ALARM_FLAGS, 8'h04, "latched overflow");
    rd(ADDR_ALARM_FLAGS, 8'h00, "overflow cleared");
    generalPinOneIn <= 1'b0;
    rd(ADDR_ALARM_FLAGS, 8'h00, "masked pin");
    wr(ADDR_ALARM_MASK, 8'h18);
    wr(ADDR_PIN_DEF, 8'h01);
    rd(ADDR_ALARM_FLAGS, 8'h08, "pin one flag");
    repeat (2) @(posedge clk_sys);
    chk("alert enable", {7'h00, generalPinZeroOe}, 8'h01);
    chk("alert level", {7'h00, generalPinZeroOut}, 8'h00);
    generalPinOneIn <= 1'b1;
    rd(ADDR_ALARM_FLAGS, 8'h08, "pin one latched");
    rd(ADDR_ALARM_FLAGS, 8'h00, "pin one cleared");
    repeat (2) @(posedge clk_sys);
    chk("alert released", {7'h00, generalPinZeroOe}, 8'h00);
    generalPinTwoIn <= 1'b0;
    rd(ADDR_ALARM_FLAGS, 8'h10, "pin two flag");
    generalPinTwoIn <= 1'b1;
    rd(ADDR_ALARM_FLAGS, 8'h10, "pin two latched");
    rd(ADDR_ALARM_FLAGS, 8'h00, "pin two cleared");
    wr(ADDR_ALARM_MASK, 8'h03);
    levelAtMin <= 1'b1;
    rd(ADDR_ALARM_FLAGS, 8'h00, "min outside closed");
    wr(ADDR_CONFIG, 8'h2A);
    rd(ADDR_ALARM_FLAGS, 8'h02, "min flag");
    levelAtMax <= 1'b1;
    rd(ADDR_ALARM_FLAGS, 8'h03, "max flag");
    levelAtMin <= 1'b0;
    levelAtMax <= 1'b0;
    rd(ADDR_ALARM_FLAGS, 8'h03, "min max latched");
    rd(ADDR_ALARM_FLAGS, 8'h00, "min max cleared");
    wr(ADDR_DAC, 8'h40);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CONFIG, {2'h0, 2'(m), 4'hA});
      repeat (2) @(posedge clk_sys);
      chk("mode", {6'h00, fanMode}, {6'h00, 2'(m)});
      chk("drive", driveLevelCode, expDrive[m]);
    end
    // Hardware full-on overrides open loop; pin zero forced low
    wr(ADDR_PIN_DEF, 8'h06);
    generalPinOneIn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("full-on pin", driveLevelCode, 8'hFF);
    chk("pin drive low", {7'h00, generalPinZeroOe}, 8'h01);
    generalPinOneIn <= 1'b1;
    repeat (50000) @(posedge clk_sys);
    rd(ADDR_DAC, 8'h40, "dac readback");
    wr(ADDR_ALARM_MASK, 8'h00);
    freeRun <= 1'b1;
    // Steady train: a full window holds an exact edge count for codes 0 to 2; code 3 saturates at 255
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_WINDOW_SEL, 8'(k));
      repeat (((3 * BASE) << k) + 20) @(posedge clk_sys);
      rd(ADDR_COUNT0, (k == 3) ? 8'hFF : 8'(50 << k), "window");
    end
    results;
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    num_errors++;
    results;
  end
endmodule
`default_nettype wire
